// [rtl/ssl_consts.vh]
// Register map, field positions and reset values of the serial line block
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH
`define SSL_OFF_RXCTRL 5'h00
`define SSL_OFF_TXCTRL 5'h04
`define SSL_OFF_PARAM 5'h08
`define SSL_OFF_RXBUF 5'h0c
`define SSL_OFF_TXBUF 5'h10
`define SSL_RXC_HUNT 0
`define SSL_RXC_IE 1
`define SSL_RXC_RING 5
`define SSL_RXC_SYNCD 6
`define SSL_RXC_DONE 7
`define SSL_TXC_SEND 0
`define SSL_TXC_HDX 1
`define SSL_TXC_IE 2
`define SSL_TXC_DONE 6
`define SSL_TXC_MRST 7
`define SSL_RXB_OVRN 14
`define SSL_MODE_ISO 2'h0
`define SSL_MODE_INT 2'h1
`define SSL_MODE_EXT 2'h2
`define SSL_PAR_RST 16'h0000
`define SSL_RXBUF_RST 8'hff
`define SSL_RESP_OKAY 2'h0
`define SSL_RESP_SLVERR 2'h2
`endif

// [rtl/ssl_sync2.v]
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module ssl_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Asynchronous in, synchronous out
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

// [rtl/ssl_top.v]
// Synchronous serial line: AXI4-Lite registers, transmitter and receiver
// How it works
// [RQ1] Reset input initializes everything, no software needed
// [RQ2] Master reset bit clears all block logic; here bus slave state, pin synchronisers and edge history are kept
// [RQ3] Ring line from modem raises receiver interrupt
// [RQ4] Load while send set starts shifting, sets done
// [RQ5] Buffered character follows current one immediately
// [RQ6] Software reloads on done, clears send at end
// [RQ7] Send cleared: finish character, then hold mark
// [RQ8] Transmit done holds its state while send clear
// [RQ9] Synchronous underrun sends the sync character
// [RQ10] Isochronous underrun pauses until next load
// [RQ11] Receiver takes serial bits only while hunting
// [RQ12] No character framed before receiver synchronized
// [RQ13] After sync, frame next character, set ready
// [RQ14] Receive ready raises receiver interrupt request
// [RQ15] Unread character overwritten sets overrun flag
// [RQ16] Bus decode yields one load strobe per register; PARAM has two, ld_par_lo and ld_par_hi, one per byte
// [RQ17] Parameter write loads receiver and transmitter copies
// [RQ18] Receive buffer read drives received data onto bus
// [RQ19] Idle: buffer ones, rx flags clear, mark, done
// [RQ20] Send with half duplex inhibits receiver clock
// [RQ21] Internal sync needs two contiguous sync characters
// [RQ22] Receiver interrupt served before transmitter interrupt
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ssl_consts.vh"
module ssl_top #(
  parameter ADDR_W = 5
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // AXI4-Lite write channels
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  output wire [1:0] s_axi_bresp_o,
  // AXI4-Lite read channels
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  // Modem side
  input wire tx_clk_i,
  input wire rx_clk_i,
  input wire rx_data_i,
  input wire ring_i,
  input wire ext_sync_i,
  output wire tx_data_o,
  // Interrupt requests
  output wire rx_irq_o,
  output wire tx_irq_o
);
  localparam TX_IDLE = 2'b01;
  localparam TX_SHIFT = 2'b10;
  localparam RX_HUNT = 4'b0001;
  localparam RX_SYN1 = 4'b0010;
  localparam RX_FRAME = 4'b0100;
  localparam RX_STOP = 4'b1000;

  // Modem pins through two flops each
  wire [4:0] pin_s;
  ssl_sync2 #(.W(5)) u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i({ext_sync_i, ring_i, rx_data_i, rx_clk_i, tx_clk_i}),
    .q_o(pin_s)
  );
  wire tclk_s = pin_s[0];
  wire rclk_s = pin_s[1];
  wire rxd_s = pin_s[2];
  wire ring_s = pin_s[3];
  wire esync_s = pin_s[4];

  reg mrst_r;
  wire srst = !resetn_i | mrst_r; // [RQ1] [RQ2]

  // Bus slave state, reset only by the reset pin so a pending answer survives
  reg aw_full_r, w_full_r, bvalid_r, rvalid_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r, rdata_r;
  reg [3:0] wstrb_r;
  reg [1:0] bresp_r, rresp_r;
  wire do_wr = aw_full_r & w_full_r & !bvalid_r;
  wire rd_go = s_axi_arvalid_i & !rvalid_r;

  // Load strobes from the address decode
  wire ld_rxc = do_wr & (awaddr_r == `SSL_OFF_RXCTRL) & wstrb_r[0]; // [RQ16]
  wire ld_txc = do_wr & (awaddr_r == `SSL_OFF_TXCTRL) & wstrb_r[0]; // [RQ16]
  wire ld_par_lo = do_wr & (awaddr_r == `SSL_OFF_PARAM) & wstrb_r[0]; // [RQ16]
  wire ld_par_hi = do_wr & (awaddr_r == `SSL_OFF_PARAM) & wstrb_r[1]; // [RQ16]
  wire ld_txb = do_wr & (awaddr_r == `SSL_OFF_TXBUF) & wstrb_r[0]; // [RQ16]
  wire wr_hit = (awaddr_r == `SSL_OFF_RXCTRL) | (awaddr_r == `SSL_OFF_TXCTRL) |
                (awaddr_r == `SSL_OFF_PARAM) | (awaddr_r == `SSL_OFF_TXBUF);
  wire rd_rxb = rd_go & (s_axi_araddr_i == `SSL_OFF_RXBUF); // [RQ18]

  // Control and status state
  reg hunt_r, rx_ie_r, ring_r, send_r, hdx_r, tx_ie_r;
  reg rx_done_r, ovrn_r, tx_done_r, tx_full_r;
  reg [15:0] rx_par_r, tx_par_r;
  reg [7:0] rxbuf_r, txbuf_r;
  reg [1:0] tx_st_r;
  reg [3:0] rx_st_r;
  reg [9:0] tx_sr_r;
  reg [3:0] tx_cnt_r, rx_cnt_r;
  reg [7:0] rx_sr_r;
  reg tx_out_r, tclk_d_r, rclk_d_r, ring_d_r;

  // Write address and data taken in either order
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `SSL_RESP_OKAY;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      mrst_r <= 1'b0;
    end else begin
      mrst_r <= ld_txc & wdata_r[`SSL_TXC_MRST]; // [RQ2]
      if (s_axi_awvalid_i & !aw_full_r) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `SSL_RESP_OKAY : `SSL_RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read answer registered one cycle after the address is taken
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SSL_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r <= `SSL_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      case (s_axi_araddr_i)
        `SSL_OFF_RXCTRL: rdata_r[7:0] <= {rx_done_r, (rx_st_r == RX_FRAME) |
          (rx_st_r == RX_STOP), ring_r, 3'h0, rx_ie_r, hunt_r};
        `SSL_OFF_TXCTRL: rdata_r[6:0] <= {tx_done_r, 3'h0, tx_ie_r, hdx_r, send_r};
        `SSL_OFF_PARAM: rdata_r[15:0] <= tx_par_r;
        `SSL_OFF_RXBUF: rdata_r[15:0] <= {1'b0, ovrn_r, 6'h00, rxbuf_r}; // [RQ18]
        `SSL_OFF_TXBUF: rdata_r <= 32'h0000_0000;
        default: rresp_r <= `SSL_RESP_SLVERR;
      endcase
    end else if (rvalid_r & s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  // Control bits and parameter copies
  always @(posedge ref_clk_i) begin
    if (srst) begin
      hunt_r <= 1'b0;
      rx_ie_r <= 1'b0;
      send_r <= 1'b0;
      hdx_r <= 1'b0;
      tx_ie_r <= 1'b0;
      rx_par_r <= `SSL_PAR_RST;
      tx_par_r <= `SSL_PAR_RST;
    end else begin
      if (ld_rxc) begin
        hunt_r <= wdata_r[`SSL_RXC_HUNT];
        rx_ie_r <= wdata_r[`SSL_RXC_IE];
      end
      if (ld_txc) begin
        send_r <= wdata_r[`SSL_TXC_SEND];
        hdx_r <= wdata_r[`SSL_TXC_HDX];
        tx_ie_r <= wdata_r[`SSL_TXC_IE];
      end
      // Both copies from one strobe so they never disagree
      if (ld_par_lo) begin
        rx_par_r[7:0] <= wdata_r[7:0]; // [RQ17]
        tx_par_r[7:0] <= wdata_r[7:0]; // [RQ17]
      end
      if (ld_par_hi) begin
        rx_par_r[15:8] <= wdata_r[15:8]; // [RQ17]
        tx_par_r[15:8] <= wdata_r[15:8]; // [RQ17]
      end
    end
  end

  // Edge history follows the pins through a master reset, so no false edge follows it
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
      ring_d_r <= 1'b0;
    end else begin
      tclk_d_r <= tclk_s;
      rclk_d_r <= rclk_s;
      ring_d_r <= ring_s;
    end
  end
  wire tx_fall = tclk_d_r & !tclk_s;
  wire rx_rise = rclk_s & !rclk_d_r;
  wire ring_rise = ring_s & !ring_d_r;

  // Transmit character geometry
  wire [1:0] tx_mode = tx_par_r[1:0];
  wire [3:0] tx_len = 4'h5 + {2'b00, tx_par_r[3:2]};
  wire [7:0] tx_mask = 8'hff >> (4'h8 - tx_len);
  wire tx_take = send_r & tx_full_r; // [RQ4] [RQ5]
  wire tx_fill = send_r & (tx_mode != `SSL_MODE_ISO) & (tx_st_r == TX_SHIFT); // [RQ9]
  wire [7:0] tx_char = tx_take ? (txbuf_r & tx_mask) : (tx_par_r[15:8] & tx_mask);
  // Isochronous frame is start bit, data, stop bit, lsb first
  wire [9:0] tx_frame = (10'h001 << (tx_len + 4'h1)) | {1'b0, tx_char, 1'b0};
  wire [9:0] tx_word = (tx_mode == `SSL_MODE_ISO) ? tx_frame : {2'b00, tx_char};
  wire [3:0] tx_bits = (tx_mode == `SSL_MODE_ISO) ? tx_len + 4'h1 : tx_len - 4'h1;

  // Transmitter: bits change on the falling modem clock edge
  always @(posedge ref_clk_i) begin
    if (srst) begin
      tx_st_r <= TX_IDLE;
      tx_out_r <= 1'b1; // [RQ19]
      tx_done_r <= 1'b1; // [RQ19]
      tx_full_r <= 1'b0;
      txbuf_r <= 8'h00;
      tx_sr_r <= 10'h3ff;
      tx_cnt_r <= 4'h0;
    end else begin
      if (tx_fall) begin
        if (tx_cnt_r != 4'h0) begin
          // Current character runs out whatever send does
          tx_out_r <= tx_sr_r[0]; // [RQ7]
          tx_sr_r <= {1'b1, tx_sr_r[9:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
        end else if (tx_take | tx_fill) begin
          tx_st_r <= TX_SHIFT;
          tx_out_r <= tx_word[0]; // [RQ4] [RQ5] [RQ9]
          tx_sr_r <= {1'b1, tx_word[9:1]};
          tx_cnt_r <= tx_bits;
          if (tx_take) begin
            tx_full_r <= 1'b0;
            tx_done_r <= 1'b1; // [RQ4]
          end
        end else begin
          // Send cleared, or isochronous underrun: rest at mark
          tx_st_r <= TX_IDLE; // [RQ7] [RQ10]
          tx_out_r <= 1'b1; // [RQ7] [RQ10]
        end
      end
      // A load refills the buffer; done only moves while send is set
      if (ld_txb) begin
        txbuf_r <= wdata_r[7:0]; // [RQ4]
        tx_full_r <= 1'b1;
        if (send_r) begin
          tx_done_r <= 1'b0; // [RQ8]
        end
      end
    end
  end

  // Receive character geometry
  wire [1:0] rx_mode = rx_par_r[1:0];
  wire [3:0] rx_len = 4'h5 + {2'b00, rx_par_r[3:2]};
  wire [7:0] rx_mask = 8'hff >> (4'h8 - rx_len);
  wire rx_en = rx_rise & hunt_r & !(send_r & hdx_r); // [RQ11] [RQ20]
  wire [7:0] rx_sr_n = {rxd_s, rx_sr_r[7:1]};
  wire [7:0] rx_char = rx_sr_n >> (4'h8 - rx_len);
  wire rx_is_sync = rx_char == (rx_par_r[15:8] & rx_mask);
  wire rx_last = rx_cnt_r == 4'h1;
  wire rx_deliver = rx_en & (rx_st_r == RX_FRAME) & rx_last; // [RQ12] [RQ13]
  wire ext_lost = (rx_mode == `SSL_MODE_EXT) & !esync_s;

  // Receiver hunt, synchronisation and framing
  always @(posedge ref_clk_i) begin
    if (srst) begin
      rx_st_r <= RX_HUNT;
      rx_sr_r <= 8'h00;
      rx_cnt_r <= 4'h0;
    end else if (!hunt_r) begin
      rx_st_r <= RX_HUNT; // [RQ11]
      rx_cnt_r <= 4'h0;
    end else if (rx_en) begin
      rx_sr_r <= rx_sr_n;
      rx_cnt_r <= rx_cnt_r - 4'h1;
      case (rx_st_r)
        RX_HUNT: begin
          if ((rx_mode == `SSL_MODE_INT) & rx_is_sync) begin
            rx_st_r <= RX_SYN1; // [RQ21]
            rx_cnt_r <= rx_len;
          end else if (((rx_mode == `SSL_MODE_EXT) & esync_s) |
                       ((rx_mode == `SSL_MODE_ISO) & !rxd_s)) begin
            rx_st_r <= RX_FRAME; // [RQ12]
            rx_cnt_r <= rx_len;
          end
        end
        RX_SYN1: begin
          // Second sync must follow the first with no gap
          if (rx_last) begin
            rx_st_r <= rx_is_sync ? RX_FRAME : RX_HUNT; // [RQ21]
            rx_cnt_r <= rx_len;
          end
        end
        RX_FRAME: begin
          if (ext_lost) begin
            rx_st_r <= RX_HUNT;
          end else if (rx_last) begin
            rx_st_r <= (rx_mode == `SSL_MODE_ISO) ? RX_STOP : RX_FRAME; // [RQ13]
            rx_cnt_r <= rx_len;
          end
        end
        RX_STOP: rx_st_r <= RX_HUNT;
        default: rx_st_r <= RX_HUNT;
      endcase
    end else if (ext_lost & (rx_st_r == RX_FRAME)) begin
      rx_st_r <= RX_HUNT;
    end
  end

  // Receive buffer and flags; a new event beats a same-cycle clear
  always @(posedge ref_clk_i) begin
    if (srst) begin
      rxbuf_r <= `SSL_RXBUF_RST; // [RQ19]
      rx_done_r <= 1'b0; // [RQ19]
      ovrn_r <= 1'b0; // [RQ19]
      ring_r <= 1'b0;
    end else begin
      if (rd_rxb) begin
        rx_done_r <= 1'b0;
        ovrn_r <= 1'b0;
      end
      if (ld_rxc & wdata_r[`SSL_RXC_RING]) begin
        ring_r <= 1'b0;
      end
      if (ring_rise) begin
        ring_r <= 1'b1; // [RQ3]
      end
      if (rx_deliver) begin
        rxbuf_r <= rx_char; // [RQ13]
        rx_done_r <= 1'b1; // [RQ13]
        if (rx_done_r & !rd_rxb) begin
          ovrn_r <= 1'b1; // [RQ15]
        end
      end
    end
  end

  // Interrupt requests, receiver ahead of transmitter
  wire rx_req = rx_ie_r & (rx_done_r | ring_r); // [RQ3] [RQ14]
  wire tx_req = tx_ie_r & tx_done_r;
  assign rx_irq_o = rx_req;
  assign tx_irq_o = tx_req & !rx_req; // [RQ22]

  // Port drives
  assign s_axi_awready_o = !aw_full_r;
  assign s_axi_wready_o = !w_full_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign tx_data_o = tx_out_r;
endmodule

// [dv/ssl_top_asserts.sv]
// Port-level checks for the serial line block
`timescale 1ns/1ps
module ssl_top_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Register bus
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  // Line and requests
  input wire tx_clk_i,
  input wire tx_data_o,
  input wire rx_irq_o,
  input wire tx_irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Idle state right after reset
  property p_idle; $rose(resetn_i) |-> tx_data_o && !rx_irq_o && !tx_irq_o; endproperty
  a_idle: assert property (p_idle) else $error("idle state wrong after reset");
  // Answers stay put until taken
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_rans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_rbusy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while answer pending");
  property p_wans;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o;
  endproperty
  a_wans: assert property (p_wans) else $error("write not answered");
  // Receiver request wins over transmitter request
  property p_prio; !(rx_irq_o && tx_irq_o); endproperty
  a_prio: assert property (p_prio) else $error("both requests high");
  // Line only moves after a bit clock edge
  property p_txq; $stable(tx_clk_i) [*6] |=> $stable(tx_data_o); endproperty
  a_txq: assert property (p_txq) else $error("line changed without bit clock");
  c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_rxirq: cover property ($rose(rx_irq_o));
  c_txirq: cover property ($rose(tx_irq_o));
endmodule

// [dv/ssl_modem.sv]
// Behavioural synchronous modem at the far end of the line
`timescale 1ns/1ps
module ssl_modem (
  // Serial data from the block
  input wire tx_data_i,
  // Bit clocks and serial data to the block
  output logic tx_clk_o,
  output logic rx_clk_o,
  output logic rx_data_o
);
  logic bits[$];
  logic [63:0] tx_hist = 64'hffffffffffffffff;
  // Free running bit clocks, receive clock offset so edges never line up
  initial begin
    tx_clk_o = 1'h0;
    forever #40 tx_clk_o = ~tx_clk_o;
  end
  initial begin
    rx_clk_o = 1'h0;
    #13;
    forever #40 rx_clk_o = ~rx_clk_o;
  end
  // Data moves on the falling edge; an empty queue toggles so stale bits never look valid
  initial rx_data_o = 1'h1;
  always @(negedge rx_clk_o) begin
    if (bits.size() > 0)
      rx_data_o <= bits.pop_front();
    else
      rx_data_o <= ~rx_data_o;
  end
  // Sent bits, newest at the top
  always @(posedge tx_clk_o)
    tx_hist <= {tx_data_i, tx_hist[63:1]};
  task automatic push(input logic [7:0] c);
    for (int i = 0; i < 8; i++)
      bits.push_back(c[i]);
  endtask
endmodule

// [dv/sync_serial_line_dataflow_tb.sv]
// Self-checking bench for the serial line block
`timescale 1ns/1ps
`include "ssl_consts.vh"
module sync_serial_line_dataflow_tb;
  logic ref_clk_i, resetn_i, awvalid, wvalid, bready, arvalid, rready, ring, ext_sync;
  logic [3:0] wstrb;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rd_v;
  logic [1:0] last_resp;
  wire awready, wready, bvalid, arready, rvalid, tx_clk, rx_clk, rx_data, tx_data, rx_irq, tx_irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int bad_count, n_tests;
  ssl_top dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .tx_clk_i(tx_clk), .rx_clk_i(rx_clk),
    .rx_data_i(rx_data), .ring_i(ring), .ext_sync_i(ext_sync), .tx_data_o(tx_data),
    .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
  ssl_modem modem_u (.tx_data_i(tx_data), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk),
    .rx_data_o(rx_data));
  // 200 MHz clock
  initial begin
    ref_clk_i = 1'h0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang;
    bad_count++;
    stop_test();
  endtask
  // Bus write: hold each channel until taken, then wait for the answer
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    last_resp = bresp;
    bready <= 1'h0;
    if (n == 64) hang();
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk_i);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    last_resp = rresp;
    rready <= 1'h0;
    if (n == 64) hang();
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
    rd(a, rd_v);
    chk(nm, rd_v, e);
  endtask
  // Software waits for done before the next load
  task automatic wait_done;
    int n;
    for (n = 0; n < 400; n++) begin
      rd(`SSL_OFF_TXCTRL, rd_v);
      if (rd_v[`SSL_TXC_DONE] === 1'h1) break;
    end
    if (n == 400) hang();
  endtask
  task automatic line_flush;
    int n;
    for (n = 0; n < 200 && modem_u.bits.size() > 0; n++)
      @(negedge rx_clk);
    @(negedge rx_clk);
    if (n == 200) hang();
  endtask
  function automatic logic [31:0] seen(input logic [63:0] h, input logic [23:0] p, input int w);
    seen = 32'h0;
    for (int o = 0; o + w <= 64; o++)
      if (((h >> o) & ((64'h1 << w) - 64'h1)) == {40'h0, p}) seen = 32'h1;
  endfunction
  task automatic t_reset;
    rc(`SSL_OFF_RXBUF, 32'h000000ff, "rx buffer");
    rc(`SSL_OFF_RXCTRL, 32'h0, "rx control");
    rc(`SSL_OFF_TXCTRL, 32'h00000040, "tx control");
    chk("mark", {31'h0, tx_data}, 32'h1);
    rd(5'h14, rd_v);
    chk("unmapped read", {30'h0, last_resp}, {30'h0, `SSL_RESP_SLVERR});
    wr(`SSL_OFF_PARAM, 32'h0000960d);
    rc(`SSL_OFF_PARAM, 32'h0000960d, "param");
    $display("test reset done");
  endtask
  task automatic t_rx;
    wr(`SSL_OFF_RXCTRL, 32'h00000002);
    modem_u.push(8'h96);
    modem_u.push(8'h96);
    modem_u.push(8'h3c);
    line_flush();
    rc(`SSL_OFF_RXCTRL, 32'h00000002, "no hunting");
    wr(`SSL_OFF_RXCTRL, 32'h00000003);
    modem_u.push(8'h96);
    modem_u.push(8'h96);
    modem_u.push(8'ha5);
    line_flush();
    rc(`SSL_OFF_RXCTRL, 32'h000000c3, "synced and ready");
    wr(`SSL_OFF_RXCTRL, 32'h00000002);
    chk("rx irq first", {31'h0, rx_irq}, 32'h1);
    // A lone sync would frame the second sync and flag overrun here
    rc(`SSL_OFF_RXBUF, 32'h000000a5, "first char");
    wr(`SSL_OFF_RXCTRL, 32'h00000003);
    modem_u.push(8'h96);
    modem_u.push(8'h96);
    modem_u.push(8'h3c);
    modem_u.push(8'ha5);
    line_flush();
    // Stop hunting before the idle toggles get framed
    wr(`SSL_OFF_RXCTRL, 32'h00000002);
    chk("rx irq", {31'h0, rx_irq}, 32'h1);
    rc(`SSL_OFF_RXBUF, 32'h000040a5, "overrun");
    rc(`SSL_OFF_RXBUF, 32'h000000a5, "rx char");
    chk("rx irq clear", {31'h0, rx_irq}, 32'h0);
    $display("test receive done");
  endtask
  task automatic t_ring;
    ring <= 1'h1;
    repeat (8) @(posedge ref_clk_i);
    chk("ring irq", {31'h0, rx_irq}, 32'h1);
    ring <= 1'h0;
    wr(`SSL_OFF_RXCTRL, 32'h00000022);
    chk("ring clear", {31'h0, rx_irq}, 32'h0);
    $display("test ring done");
  endtask
  task automatic t_tx;
    wr(`SSL_OFF_TXCTRL, 32'h00000005);
    wr(`SSL_OFF_TXBUF, 32'h00000041);
    wait_done();
    wr(`SSL_OFF_TXBUF, 32'h000000c3);
    wait_done();
    chk("tx irq", {31'h0, tx_irq}, 32'h1);
    ring <= 1'h1;
    repeat (8) @(posedge ref_clk_i);
    chk("tx irq yields", {31'h0, tx_irq}, 32'h0);
    chk("rx irq wins", {31'h0, rx_irq}, 32'h1);
    ring <= 1'h0;
    wr(`SSL_OFF_RXCTRL, 32'h00000022);
    repeat (30) @(posedge tx_clk);
    chk("tx order", seen(modem_u.tx_hist, 24'h96c341, 24), 32'h1);
    wr(`SSL_OFF_TXCTRL, 32'h00000004);
    repeat (24) @(posedge tx_clk);
    chk("mark after send", {16'h0, modem_u.tx_hist[63:48]}, 32'h0000ffff);
    rc(`SSL_OFF_TXCTRL, 32'h00000044, "done kept");
    $display("test transmit done");
  endtask
  task automatic t_iso;
    wr(`SSL_OFF_PARAM, 32'h0000960c);
    wr(`SSL_OFF_TXCTRL, 32'h00000001);
    wr(`SSL_OFF_TXBUF, 32'h0000005a);
    repeat (24) @(posedge tx_clk);
    chk("iso char", seen(modem_u.tx_hist, {14'h0, 1'h1, 8'h5a, 1'h0}, 10), 32'h1);
    chk("iso pause", {20'h0, modem_u.tx_hist[63:52]}, 32'h00000fff);
    wr(`SSL_OFF_TXCTRL, 32'h0);
    $display("test isochronous done");
  endtask
  task automatic t_ext;
    wr(`SSL_OFF_PARAM, 32'h0000960e);
    wr(`SSL_OFF_TXCTRL, 32'h00000003);
    wr(`SSL_OFF_RXCTRL, 32'h00000001);
    ext_sync <= 1'h1;
    repeat (40) @(posedge ref_clk_i);
    rc(`SSL_OFF_RXCTRL, 32'h00000001, "half duplex hold");
    ext_sync <= 1'h0;
    wr(`SSL_OFF_TXCTRL, 32'h0);
    // Sync goes high one bit ahead, so framing starts at the first pushed bit
    @(negedge rx_clk);
    @(posedge ref_clk_i);
    ext_sync <= 1'h1;
    @(posedge rx_clk);
    modem_u.push(8'hc5);
    line_flush();
    wr(`SSL_OFF_RXCTRL, 32'h0);
    ext_sync <= 1'h0;
    rc(`SSL_OFF_RXBUF, 32'h000000c5, "ext sync char");
    $display("test external sync done");
  endtask
  task automatic t_mrst;
    wr(`SSL_OFF_TXBUF, 32'h00000011);
    rc(`SSL_OFF_TXCTRL, 32'h00000040, "done kept on idle load");
    wr(`SSL_OFF_TXCTRL, 32'h00000080);
    rc(`SSL_OFF_PARAM, 32'h0, "param cleared");
    rc(`SSL_OFF_RXCTRL, 32'h0, "rx control cleared");
    rc(`SSL_OFF_TXCTRL, 32'h00000040, "tx control idle");
    wr(5'h18, 32'h1);
    chk("unmapped write", {30'h0, last_resp}, {30'h0, `SSL_RESP_SLVERR});
    wstrb <= 4'h2;
    wr(`SSL_OFF_PARAM, 32'h0000a5ff);
    wstrb <= 4'hf;
    rc(`SSL_OFF_PARAM, 32'h0000a500, "param high byte only");
    $display("test master reset done");
  endtask
  // Main sequence
  initial begin
    resetn_i = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, ring} = 6'h0;
    awaddr = 5'h0;
    araddr = 5'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    ext_sync = 1'h0;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    t_reset();
    t_rx();
    t_ring();
    t_tx();
    t_iso();
    t_ext();
    t_mrst();
    stop_test();
  end
endmodule
bind ssl_top ssl_top_chk chk_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o), .tx_clk_i(tx_clk_i),
  .tx_data_o(tx_data_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
